// ### ptb_logic_block.sv
// One configurable sum-of-products logic block with its matrix input stage.
// Assumes all pin inputs are asynchronous and other blocks share clk.
//
// The address map and strobed register access were decided locally.
`timescale 1ns/1ns

module ptb_logic_block
	import ptb_pkg::*;
(
	input  wire logic          clk,
	input  wire logic          reset_n,
	input  wire logic          ce,
	input  wire ptb_bus_req_t  bus_req,
	output logic [31:0]        rd_data,
	input  wire logic [3:0]    ded_in,
	input  wire logic [1:0]    clk_pin,
	input  wire logic [31:0]   pin_in,
	input  wire logic [47:0]   xfb_in,
	input  wire logic [7:0]    io_in,
	output logic [7:0]         io_out,
	output logic [7:0]         io_oe,
	output logic [15:0]        fb_out,
	output logic [7:0]         pin_fb_out
);

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	logic [3:0]              ded_s1, ded_s2;       // Dedicated input synchroniser
	logic [1:0]              ckp_s1, ckp_s2;       // Clock pin synchroniser
	logic [1:0]              ckp_d3;               // Delayed copy for edge detect
	logic [31:0]             pin_s1, pin_s2;       // Device pin synchroniser
	logic [7:0]              io_s1, io_s2;         // Own I/O pin synchroniser
	logic [1:0]              ckp_rise;             // Rising edge of each clock pin
	logic                    run;                  // Block in operation
	logic [21:0]             tmask [PTB_NUM_PT];   // True-input masks
	logic [21:0]             cmask [PTB_NUM_PT];   // Complement-input masks
	ptb_mc_cfg_t             mc_cfg [PTB_NUM_MC];  // Per macrocell setup
	ptb_cl_cfg_t             cl_cfg [PTB_NUM_CL];  // Per cluster steering
	logic [6:0]              sel [PTB_NUM_IN];     // Matrix source per array input
	logic [PTB_NUM_SRC-1:0]  src;                  // All selectable sources
	logic [21:0]             arr_in;               // Array inputs
	logic [PTB_NUM_PT-1:0]   pt;                   // Product term values
	logic [PTB_NUM_CL-1:0]   cl_sum;               // Sum of each cluster
	logic [PTB_NUM_MC-1:0]   sum;                  // Sum term of each macrocell
	logic [PTB_NUM_MC-1:0]   q;                    // Macrocell storage
	logic [PTB_NUM_MC-1:0]   mc_out;               // Macrocell output after polarity
	logic [31:0]             next_rd_data;         // Read mux
	logic [2:0]              rg;                   // Addressed region
	logic [6:0]              idx;                  // Addressed index
	logic                    cfg_we;               // Config write allowed

	assign rg     = bus_req.addr[PTB_ADDR_W-1:PTB_RG_POS];
	assign idx    = bus_req.addr[PTB_RG_POS-1:0];
	// Writes to setup are dropped while running, so logic never sees a half-loaded map
	assign cfg_we = bus_req.wr && !run;

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	// Two flops on every pin input; logic reads the second, and clock pin edge detect also reads a third
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			ded_s1 <= 4'h0;
			ded_s2 <= 4'h0;
			ckp_s1 <= 2'h0;
			ckp_s2 <= 2'h0;
			ckp_d3 <= 2'h0;
			pin_s1 <= 32'h0;
			pin_s2 <= 32'h0;
			io_s1  <= 8'h0;
			io_s2  <= 8'h0;
		end
		else if (ce)
		begin
			ded_s1 <= ded_in;
			ded_s2 <= ded_s1;
			ckp_s1 <= clk_pin;
			ckp_s2 <= ckp_s1;
			ckp_d3 <= ckp_s2;
			pin_s1 <= pin_in;
			pin_s2 <= pin_s1;
			io_s1  <= io_in;
			io_s2  <= io_s1;
		end
	end

	// Clock pins are sampled, so their rate must stay well below clk
	assign ckp_rise = ckp_s2 & ~ckp_d3;

	// ----------------------------------------------------------------
	// Register port: control
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			run <= 1'b0;
		else if (ce && bus_req.wr && rg == PTB_RG_CTRL && idx == PTB_IDX_CTRL)
			run <= bus_req.wdata[PTB_CTRL_RUN];
	end

	// ----------------------------------------------------------------
	// Register port: product term masks
	// ----------------------------------------------------------------
	// 64 logic terms plus the four special terms
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			for (int t = 0; t < PTB_NUM_PT; t++)
			begin
				tmask[t] <= PTB_RST_MASK;
				cmask[t] <= PTB_RST_MASK;
			end
		end
		else if (ce && cfg_we && int'(idx) < PTB_NUM_PT)
		begin
			if (rg == PTB_RG_TRUE)
				tmask[idx] <= bus_req.wdata[21:0];
			else if (rg == PTB_RG_COMP)
				cmask[idx] <= bus_req.wdata[21:0];
		end
	end

	// ----------------------------------------------------------------
	// Register port: macrocells, clusters, matrix selects
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			for (int m = 0; m < PTB_NUM_MC; m++)
				mc_cfg[m] <= PTB_RST_MC;
		end
		else if (ce && cfg_we && rg == PTB_RG_MC && int'(idx) < PTB_NUM_MC)
			mc_cfg[idx[3:0]] <= ptb_mc_cfg_t'(bus_req.wdata[6:0]);
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			for (int c = 0; c < PTB_NUM_CL; c++)
				cl_cfg[c] <= PTB_RST_CL;
		end
		else if (ce && cfg_we && rg == PTB_RG_CL && int'(idx) < PTB_NUM_CL)
			cl_cfg[idx[3:0]] <= ptb_cl_cfg_t'(bus_req.wdata[4:0]);
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			for (int i = 0; i < PTB_NUM_IN; i++)
				sel[i] <= PTB_RST_SEL;
		end
		else if (ce && cfg_we && rg == PTB_RG_SEL && int'(idx) < PTB_NUM_IN)
			sel[idx[4:0]] <= bus_req.wdata[6:0];
	end

	// ----------------------------------------------------------------
	// Register port: read data, valid only the cycle after the strobe
	// ----------------------------------------------------------------
	always_comb
	begin
		next_rd_data = 32'h0;
		case (rg)
			PTB_RG_CTRL:
			begin
				if (idx == PTB_IDX_CTRL)
					next_rd_data[PTB_CTRL_RUN] = run;
				else if (idx == PTB_IDX_STAT)
					next_rd_data[23:0] = {io_s2, q};  // Live pins and storage
			end
			PTB_RG_TRUE: if (int'(idx) < PTB_NUM_PT) next_rd_data[21:0] = tmask[idx];
			PTB_RG_COMP: if (int'(idx) < PTB_NUM_PT) next_rd_data[21:0] = cmask[idx];
			PTB_RG_MC:   if (int'(idx) < PTB_NUM_MC) next_rd_data[6:0] = mc_cfg[idx[3:0]];
			PTB_RG_CL:   if (int'(idx) < PTB_NUM_CL) next_rd_data[4:0] = cl_cfg[idx[3:0]];
			PTB_RG_SEL:  if (int'(idx) < PTB_NUM_IN) next_rd_data[6:0] = sel[idx[4:0]];
			default:     next_rd_data = 32'h0;     // Unmapped reads as zero
		endcase
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			rd_data <= 32'h0;
		else if (ce)
			rd_data <= bus_req.rd ? next_rd_data : 32'h0;
	end

	// ----------------------------------------------------------------
	// Switch matrix input stage
	// ----------------------------------------------------------------
	// Own feedback comes from fb_out, so the pin never sits in this path
	assign src = {xfb_in, fb_out, pin_s2, ckp_s2, ded_s2};

	always_comb
	begin
		arr_in = 22'h0;
		for (int i = 0; i < PTB_NUM_IN; i++)
		begin
			// Out-of-range select reads low rather than X
			arr_in[i] = (int'(sel[i]) < PTB_NUM_SRC) ? src[sel[i]] : 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Product term array and allocator
	// ----------------------------------------------------------------
	always_comb
	begin
		pt = '0;
		for (int t = 0; t < PTB_NUM_PT; t++)
			pt[t] = ptb_term(arr_in, tmask[t], cmask[t]);
	end

	// Clusters of four consecutive terms
	always_comb
	begin
		cl_sum = '0;
		for (int c = 0; c < PTB_NUM_CL; c++)
			cl_sum[c] = |pt[c*PTB_CL_SIZE +: PTB_CL_SIZE];
	end

	// A cluster lands in one macrocell only, and only inside its window
	always_comb
	begin
		sum = '0;
		for (int m = 0; m < PTB_NUM_MC; m++)
		begin
			for (int c = 0; c < PTB_NUM_CL; c++)
			begin
				// At most four clusters reach a cell: sixteen terms
				if (cl_cfg[c].en && cl_cfg[c].owner == 4'(m) && ptb_eligible(m, c))
					sum[m] = sum[m] | cl_sum[c];
			end
		end
	end

	// ----------------------------------------------------------------
	// Macrocell storage
	// ----------------------------------------------------------------
	// Reset and preset terms act on every cell at once; reset wins if both
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			q <= 16'h0;
		else if (ce && run)
		begin
			if (pt[PTB_PT_AR])
				q <= 16'h0;
			else if (pt[PTB_PT_AP])
				q <= 16'hFFFF;
			else
			begin
				for (int m = 0; m < PTB_NUM_MC; m++)
				begin
					case (mc_cfg[m].mode)
						PTB_MODE_REG_D:
							if (ckp_rise[mc_cfg[m].clk_sel]) q[m] <= sum[m];
						PTB_MODE_REG_T:
							if (ckp_rise[mc_cfg[m].clk_sel] && sum[m]) q[m] <= ~q[m];
						PTB_MODE_LATCH:
							if (!ckp_s2[mc_cfg[m].clk_sel]) q[m] <= sum[m];
						PTB_MODE_IN_REG:
							if (m % 2 == 1 && ckp_rise[mc_cfg[m].clk_sel]) q[m] <= io_s2[m/2];
						PTB_MODE_IN_LATCH:
							if (m % 2 == 1 && !ckp_s2[mc_cfg[m].clk_sel]) q[m] <= io_s2[m/2];
						default:
							q[m] <= q[m];                // Combinatorial keeps no state
					endcase
				end
			end
		end
	end

	// Polarity sits after storage; combinatorial cells bypass storage but still pass through polarity
	always_comb
	begin
		mc_out = '0;
		for (int m = 0; m < PTB_NUM_MC; m++)
			mc_out[m] = ((mc_cfg[m].mode == PTB_MODE_COMB) ? sum[m] : q[m]) ^ mc_cfg[m].pol;
	end

	// ----------------------------------------------------------------
	// Feedback and I/O cells
	// ----------------------------------------------------------------
	// Outputs are registered, so each adds one clk of latency
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			fb_out     <= 16'h0;
			pin_fb_out <= 8'h0;
		end
		else if (ce)
		begin
			fb_out     <= mc_out;
			pin_fb_out <= io_s2;
		end
	end

	// Even macrocells drive the pins; buried odd ones never do
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			io_out <= 8'h0;
			io_oe  <= 8'h0;
		end
		else if (ce)
		begin
			for (int k = 0; k < PTB_NUM_IO; k++)
			begin
				io_out[k] <= mc_out[2*k];
				if (!run)
					io_oe[k] <= 1'b0;               // Pins stay released until running
				else
				begin
					case (mc_cfg[2*k].oe)
						PTB_OE_ON:  io_oe[k] <= 1'b1;
						PTB_OE_PT0: io_oe[k] <= pt[PTB_PT_OE0];
						PTB_OE_PT1: io_oe[k] <= pt[PTB_PT_OE1];
						default:    io_oe[k] <= 1'b0;
					endcase
				end
			end
		end
	end

endmodule // ptb_logic_block

// ### ptb_pkg.sv
// Shared constants, types and helpers for one product-term logic block.
// Assumes a single 20 MHz system clock and a plain register port.
package ptb_pkg;

	// ----------------------------------------------------------------
	// Array geometry
	// ----------------------------------------------------------------
	localparam int PTB_NUM_IN   = 22;          // Array inputs from the switch matrix
	localparam int PTB_NUM_LT   = 64;          // Logic product terms
	localparam int PTB_NUM_PT   = 68;          // Logic plus special terms
	localparam int PTB_NUM_MC   = 16;          // Output and buried macrocells
	localparam int PTB_NUM_IO   = 8;           // I/O cells
	localparam int PTB_NUM_CL   = 16;          // Clusters of product terms
	localparam int PTB_CL_SIZE  = 4;           // Terms in one cluster
	localparam int PTB_PT_OE0   = 64;          // Output enable term 0
	localparam int PTB_PT_OE1   = 65;          // Output enable term 1
	localparam int PTB_PT_AR    = 66;          // Common reset term
	localparam int PTB_PT_AP    = 67;          // Common preset term

	// ----------------------------------------------------------------
	// Switch matrix sources, offsets into the source vector
	// ----------------------------------------------------------------
	localparam int PTB_NUM_DED  = 4;           // Dedicated input pins
	localparam int PTB_NUM_CKP  = 2;           // Clock pins usable as inputs
	localparam int PTB_NUM_PIN  = 32;          // Bidirectional pins of the device
	localparam int PTB_NUM_XFB  = 48;          // Macrocell feedback of three other blocks
	localparam int PTB_NUM_SRC  = 102;         // Total selectable sources
	localparam int PTB_SRC_DED  = 0;
	localparam int PTB_SRC_CKP  = 4;
	localparam int PTB_SRC_PIN  = 6;
	localparam int PTB_SRC_OWN  = 38;
	localparam int PTB_SRC_XFB  = 54;

	// ----------------------------------------------------------------
	// Register map: addr[9:7] region, addr[6:0] index
	// ----------------------------------------------------------------
	localparam int         PTB_ADDR_W   = 10;
	localparam int         PTB_RG_POS   = 7;
	localparam logic [2:0] PTB_RG_CTRL  = 3'h0; // Control and status
	localparam logic [2:0] PTB_RG_TRUE  = 3'h1; // True-input masks, one per term
	localparam logic [2:0] PTB_RG_COMP  = 3'h2; // Complement-input masks
	localparam logic [2:0] PTB_RG_MC    = 3'h3; // Macrocell configuration
	localparam logic [2:0] PTB_RG_CL    = 3'h4; // Cluster steering
	localparam logic [2:0] PTB_RG_SEL   = 3'h5; // Matrix source selects
	localparam logic [6:0] PTB_IDX_CTRL = 7'h00;
	localparam logic [6:0] PTB_IDX_STAT = 7'h01;
	localparam int         PTB_CTRL_RUN = 0;    // Run bit position

	// ----------------------------------------------------------------
	// Configuration types and reset values
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		PTB_MODE_COMB     = 3'h0,
		PTB_MODE_REG_D    = 3'h1,
		PTB_MODE_REG_T    = 3'h3,
		PTB_MODE_LATCH    = 3'h2,
		PTB_MODE_IN_REG   = 3'h6,
		PTB_MODE_IN_LATCH = 3'h7
	} ptb_mode_t;

	typedef enum logic [1:0] {
		PTB_OE_OFF = 2'h0,
		PTB_OE_ON  = 2'h1,
		PTB_OE_PT0 = 2'h2,
		PTB_OE_PT1 = 2'h3
	} ptb_oe_t;

	typedef struct packed {
		ptb_oe_t   oe;        // Three-state control, output macrocells only
		logic      clk_sel;   // Which clock pin clocks or gates this cell
		logic      pol;       // Output inversion
		ptb_mode_t mode;
	} ptb_mc_cfg_t;

	typedef struct packed {
		logic       en;       // Cluster in use
		logic [3:0] owner;    // Macrocell receiving the cluster
	} ptb_cl_cfg_t;

	typedef struct packed {
		logic                  wr;
		logic                  rd;
		logic [PTB_ADDR_W-1:0] addr;
		logic [31:0]           wdata;
	} ptb_bus_req_t;

	localparam logic [21:0] PTB_RST_MASK = 22'h3FFFFF; // Term reads false, as with intact fuses
	localparam ptb_mc_cfg_t PTB_RST_MC   = '{oe: PTB_OE_OFF, clk_sel: 1'b0, pol: 1'b0, mode: PTB_MODE_COMB};
	localparam ptb_cl_cfg_t PTB_RST_CL   = '{en: 1'b0, owner: 4'h0};
	localparam logic [6:0]  PTB_RST_SEL  = 7'h00;

	// Cluster c may feed macrocell m when m-1 <= c <= m+2
	function automatic logic ptb_eligible(input int m, input int c);
		return (c + 1 >= m) && (c <= m + 2);
	endfunction

	// One product term over true and complement masks
	function automatic logic ptb_term(input logic [21:0] in_v, input logic [21:0] tm, input logic [21:0] cm);
		return &((in_v | ~tm) & (~in_v | ~cm));
	endfunction

endpackage

// ### ptb_chk.sv
// Port checker for one product-term logic block.
// Assumes one clock domain and the register map of the package.
`timescale 1ns/1ns
module ptb_chk
	import ptb_pkg::*;
(
	input wire logic         clk,
	input wire logic         reset_n,
	input wire logic         ce,
	input wire ptb_bus_req_t bus_req,
	input wire logic [31:0]  rd_data,
	input wire logic [7:0]   io_in,
	input wire logic [7:0]   io_out,
	input wire logic [7:0]   io_oe,
	input wire logic [15:0]  fb_out,
	input wire logic [7:0]   pin_fb_out
);
	// ------------------------------------------------------------
	// Helper state
	// ------------------------------------------------------------
	logic [2:0] age;   // Edges since reset, saturating
	logic       run_q; // Shadow of the run bit

	// Age keeps $past away from values taken during reset
	always_ff @(posedge clk or negedge reset_n)
		if (!reset_n)
			age <= 3'h0;
		else if (age != 3'h7)
			age <= age + 3'h1;

	// Run bit follows control writes; region 0 is never refused
	always_ff @(posedge clk or negedge reset_n)
		if (!reset_n)
			run_q <= 1'b0;
		else if (ce && bus_req.wr && bus_req.addr == 10'h000)
			run_q <= bus_req.wdata[PTB_CTRL_RUN];

	// ------------------------------------------------------------
	// Properties
	// ------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	sequence s_ctrl_rd;
		ce && bus_req.rd && bus_req.addr == 10'h000;
	endsequence
	sequence s_status_rd;
		ce && bus_req.rd && bus_req.addr == 10'h001;
	endsequence

	property p_rst_idle;
		!$past(reset_n) |-> io_out == 8'h00 && io_oe == 8'h00 && fb_out == 16'h0000 && rd_data == 32'h0;
	endproperty
	property p_ctrl_rd;
		s_ctrl_rd |=> rd_data == {31'h0, $past(run_q)};
	endproperty
	property p_status_rd;
		s_status_rd |=> rd_data[31:24] == 8'h00 && rd_data[23:16] == pin_fb_out;
	endproperty
	property p_term_range;
		ce && bus_req.rd && (bus_req.addr[9:7] == 3'h1 || bus_req.addr[9:7] == 3'h2) && bus_req.addr[6:0] > 7'h43
			|=> rd_data == 32'h0;
	endproperty
	property p_sel_range;
		ce && bus_req.rd && bus_req.addr[9:7] == 3'h5 && bus_req.addr[6:0] > 7'h15 |=> rd_data == 32'h0;
	endproperty
	property p_rd_quiet;
		age > 3'h1 && $past(ce) && !$past(bus_req.rd) |-> rd_data == 32'h0;
	endproperty
	property p_frozen;
		age > 3'h1 && !$past(ce) |-> $stable(io_out) && $stable(io_oe) && $stable(fb_out) && $stable(rd_data);
	endproperty
	property p_pin_fb;
		age > 3'h3 && $past(ce) && $past(ce, 2) && $past(ce, 3) |-> pin_fb_out == $past(io_in, 3);
	endproperty
	property p_oe_stop;
		age > 3'h1 && $past(ce) && !run_q && !$past(run_q) |-> io_oe == 8'h00;
	endproperty

	a_rst_idle: assert property (p_rst_idle) else $error("outputs not idle after reset");
	a_ctrl_rd: assert property (p_ctrl_rd) else $error("control read wrong");
	a_status_rd: assert property (p_status_rd) else $error("status pins wrong");
	a_term_range: assert property (p_term_range) else $error("term past 67 read nonzero");
	a_sel_range: assert property (p_sel_range) else $error("select past 21 read nonzero");
	a_rd_quiet: assert property (p_rd_quiet) else $error("read data without read");
	a_frozen: assert property (p_frozen) else $error("outputs moved with enable low");
	a_pin_fb: assert property (p_pin_fb) else $error("pin feedback latency wrong");
	a_oe_stop: assert property (p_oe_stop) else $error("pin driven while stopped");
endmodule // ptb_chk

// ### ptb_board.sv
// Board model on the block's I/O pins and the two clock pins.
// Assumes the testbench sets its drive and calls its pulse task.
`timescale 1ns/1ns
module ptb_board
	import ptb_pkg::*;
(
	input  wire logic [7:0] io_out,
	input  wire logic [7:0] io_oe,
	input  wire logic       clk,
	output logic [7:0]      io_in,
	output logic [1:0]      clk_pin
);
	logic [7:0] ext_val = 8'h00; // Board drive level
	logic [7:0] ext_en  = 8'h00; // Board drive enable

	initial clk_pin = 2'h0;

	// Wire level: device first, else board, else pull-up
	always_comb
		for (int k = 0; k < 8; k++)
			io_in[k] = io_oe[k] ? io_out[k] : (ext_en[k] ? ext_val[k] : 1'b1);

	// Slow pulse: four cycles each phase so the synchroniser sees it
	task automatic pulse(input int k);
		@(posedge clk);
		clk_pin[k] <= 1'b1;
		repeat (4) @(posedge clk);
		clk_pin[k] <= 1'b0;
		repeat (4) @(posedge clk);
	endtask
endmodule // ptb_board

// ### tb.sv
// Self-checking bench for one product-term logic block.
// Assumes the board model on the pins and the checker bound below.
`timescale 1ns/1ns
module tb;
	import ptb_pkg::*;
	// ------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------
	logic         clk     = 1'b0;
	logic         reset_n = 1'b0;
	logic         ce      = 1'b1;
	ptb_bus_req_t bus_req = '0;
	logic [3:0]   ded_in  = 4'h0;
	logic [23:0]  pin_hi  = 24'h000000; // Other blocks' pins, idle
	logic [47:0]  xfb     = 48'h0;      // Other blocks' macrocell feedback
	logic [31:0]  rd_data;
	logic [31:0]  got;                  // Last read word
	logic [7:0]   io_in, io_out, io_oe, pin_fb_out;
	logic [15:0]  fb_out;
	logic [1:0]   clk_pin;
	int           error_cnt = 0;
	int           tests_run = 0;
	int           cyc       = 0;

	always #25 clk = ~clk;

	ptb_logic_block uut (.clk(clk), .reset_n(reset_n), .ce(ce), .bus_req(bus_req), .rd_data(rd_data),
		.ded_in(ded_in), .clk_pin(clk_pin), .pin_in({pin_hi, io_in}), .xfb_in(xfb), .io_in(io_in),
		.io_out(io_out), .io_oe(io_oe), .fb_out(fb_out), .pin_fb_out(pin_fb_out));
	ptb_board brd (.io_out(io_out), .io_oe(io_oe), .clk(clk), .io_in(io_in), .clk_pin(clk_pin));

	// ------------------------------------------------------------
	// Bus and compare tasks
	// ------------------------------------------------------------
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		tests_run++;
		if (g !== e)
		begin
			error_cnt++;
			$display("[ERR] %0t got %h expected %h", $time, g, e);
		end
	endtask
	task automatic wr(input logic [9:0] a, input logic [31:0] d);
		@(posedge clk);
		bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge clk);
		bus_req.wr <= 1'b0;
	endtask
	// Data stands only in the cycle after the strobe
	task automatic rd(input logic [9:0] a);
		@(posedge clk);
		bus_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
		@(posedge clk);
		bus_req.rd <= 1'b0;
		// Taken at the end of its cycle, before this edge clears it
		@(posedge clk);
		got = rd_data;
	endtask
	task automatic run(input logic r);
		wr(10'h000, {31'h0, r});
	endtask
	task automatic settle;
		repeat (6) @(posedge clk);
	endtask

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	// Reset values, range edges and an unmapped write
	task automatic t_reset;
		logic [9:0]  a [10] = '{10'h000, 10'h001, 10'h080, 10'h0C3, 10'h0C4, 10'h143, 10'h180, 10'h20F,
			10'h296, 10'h300};
		logic [31:0] e [10] = '{32'h0, 32'h00FF0000, 32'h003FFFFF, 32'h003FFFFF, 32'h0, 32'h003FFFFF, 32'h0,
			32'h0, 32'h0, 32'h0};
		wr(10'h300, 32'h1);
		for (int i = 0; i < 10; i++)
		begin
			rd(a[i]);
			chk(got, e[i]);
		end
		ce <= 1'b0;
		repeat (3) @(posedge clk);
		ce <= 1'b1;
	endtask
	// D and toggle storage, clock pin choice, refused write
	task automatic t_dreg;
		wr(10'h080, 32'h1);        // Term 0 needs input 0, which is ded_in[0]
		wr(10'h100, 32'h0);
		wr(10'h200, 32'h10);       // Cluster 0 to macrocell 0
		wr(10'h180, 32'h21);       // D type, clock pin 0, always driven
		run(1'b1);
		wr(10'h180, 32'h23);       // Must be ignored while running
		rd(10'h180);
		chk(got, 32'h21);
		ded_in <= 4'h1;
		settle;
		ce <= 1'b0;                // Frozen: this clock pin edge must be missed
		brd.pulse(0);
		ce <= 1'b1;
		chk(32'(io_out[0]), 32'h0);
		brd.pulse(0);
		chk(32'({fb_out[0], io_oe[0], io_out[0]}), 32'h7);
		ded_in <= 4'h0;
		settle;
		brd.pulse(1);
		chk(32'(io_out[0]), 32'h1);
		brd.pulse(0);
		chk(32'(io_out[0]), 32'h0);
		run(1'b0);
		wr(10'h180, 32'h23);       // Toggle type
		run(1'b1);
		ded_in <= 4'h1;
		settle;
		brd.pulse(0);
		chk(32'(io_out[0]), 32'h1);
		brd.pulse(0);
		chk(32'(io_out[0]), 32'h0);
	endtask
	// Cluster reach, polarity and enable-term choice
	task automatic t_alloc;
		run(1'b0);
		ded_in <= 4'h0;
		wr(10'h0C0, 32'h0);        // Enable term 0 always true
		wr(10'h140, 32'h0);
		wr(10'h08C, 32'h0);        // Term 12 of cluster 3 always true
		wr(10'h10C, 32'h0);
		wr(10'h203, 32'h10);       // Cluster 3 lies outside macrocell 0 reach
		wr(10'h180, 32'h40);       // Combinatorial, enable from term 64
		run(1'b1);
		settle;
		chk(32'({io_oe[0], io_out[0]}), 32'h2);
		run(1'b0);
		wr(10'h088, 32'h0);        // Term 8 of cluster 2 always true
		wr(10'h108, 32'h0);
		wr(10'h202, 32'h10);       // Cluster 2 is within reach
		run(1'b1);
		settle;
		chk(32'(io_out[0]), 32'h1);
		run(1'b0);
		wr(10'h180, 32'h68);       // Inverted, enable from term 65, still false
		run(1'b1);
		settle;
		chk(32'({io_oe[0], io_out[0]}), 32'h0);
	endtask
	// Input register on a buried cell, then block reset and preset
	task automatic t_init;
		run(1'b0);
		wr(10'h181, 32'h06);       // Input register on pin 0, clock pin 0
		run(1'b1);
		brd.ext_en  <= 8'h01;
		brd.ext_val <= 8'h01;
		settle;
		brd.pulse(0);
		chk(32'(fb_out[1]), 32'h1);
		run(1'b0);
		wr(10'h0C2, 32'h0);        // Reset term always true
		wr(10'h142, 32'h0);
		run(1'b1);
		settle;
		chk(32'(fb_out[1]), 32'h0);
		rd(10'h001);               // Every cell cleared together, pin 0 driven high by the board, the rest pulled high
		chk(got, 32'h00FF0000);
		run(1'b0);
		wr(10'h0C2, 32'h3FFFFF);
		wr(10'h0C3, 32'h0);        // Preset term always true
		wr(10'h143, 32'h0);
		run(1'b1);
		settle;
		chk(32'(fb_out[1]), 32'h1);
		rd(10'h001);               // Every cell set together
		chk(got, 32'h00FFFFFF);
	endtask
	// Matrix routing from other blocks, device pins and own feedback
	task automatic t_matrix;
		run(1'b0);
		wr(10'h084, 32'h2);        // Term 4 needs array input 1
		wr(10'h104, 32'h0);
		wr(10'h201, 32'h12);       // Cluster 1 to macrocell 2
		wr(10'h182, 32'h20);       // Combinatorial, always driven on pin 1
		wr(10'h281, 32'h3B);       // Input 1 from other blocks' feedback bit 5
		run(1'b1);
		xfb <= 48'h20;
		settle;
		chk(32'(io_out[1]), 32'h1);
		xfb <= 48'h0;
		settle;
		chk(32'(io_out[1]), 32'h0);
		run(1'b0);
		wr(10'h281, 32'h11);       // Input 1 from device pin 11
		run(1'b1);
		pin_hi <= 24'h000008;
		settle;
		chk(32'(io_out[1]), 32'h1);
		run(1'b0);
		wr(10'h281, 32'h26);       // Input 1 from macrocell 0 logic, low while its pin reads high
		run(1'b1);
		settle;
		chk(32'(io_out[1]), 32'h0);
	endtask

	// ------------------------------------------------------------
	// Sequence, hang guard and verdict
	// ------------------------------------------------------------
	task automatic end_of_test;
		$display("Comparisons %0d, mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	initial
	begin
		repeat (4) @(posedge clk);
		reset_n <= 1'b1;
		t_reset;
		$display("t_reset done");
		t_dreg;
		$display("t_dreg done");
		t_alloc;
		$display("t_alloc done");
		t_init;
		$display("t_init done");
		t_matrix;
		$display("t_matrix done");
		end_of_test;
	end

	// Whole run needs well under a thousand cycles
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 3000)
		begin
			error_cnt++;
			end_of_test;
		end
	end
endmodule // tb

bind ptb_logic_block ptb_chk chk (.clk(clk), .reset_n(reset_n), .ce(ce), .bus_req(bus_req), .rd_data(rd_data),
	.io_in(io_in), .io_out(io_out), .io_oe(io_oe), .fb_out(fb_out), .pin_fb_out(pin_fb_out));
